// ===== hdl/cpualu_pkg.sv
// package for the cpu alu and bit-operation datapath
// assumes one clock, REF_CLK at 10 MHz, and a sequencer that issues one op at a time
package cpualu_pkg;
	// clock period in ns
	localparam int CLK_PERIOD_NS = 100;
	// short-direct window bounds
	localparam logic [15:0] SADDR_LOW  = 16'hFE20;
	localparam logic [15:0] SADDR_HIGH = 16'hFF1F;
	// status word bit positions
	localparam int PSW_CY_BIT = 0;
	localparam int PSW_AC_BIT = 4;
	localparam int PSW_Z_BIT  = 6;
	// reset values
	localparam logic [7:0]  PSW_RESET = 8'h02;
	localparam logic [15:0] AX_RESET  = 16'h0000;
	// clock counts: short form (internal ram / no data) and long form
	localparam logic [4:0] CYC_SUB_IMM     = 5'd4;
	localparam logic [4:0] CYC_SUBB_SADDR  = 5'd6;
	localparam logic [4:0] CYC_SUBB_SADDRL = 5'd8;
	localparam logic [4:0] CYC_LOGIC_IDX   = 5'd8;
	localparam logic [4:0] CYC_LOGIC_IDXL  = 5'd9;
	localparam logic [4:0] CYC_WORD        = 5'd6;
	localparam logic [4:0] CYC_MUL         = 5'd16;
	localparam logic [4:0] CYC_DIV         = 5'd25;
	localparam logic [4:0] CYC_INC_MEM     = 5'd4;
	localparam logic [4:0] CYC_INC_MEML    = 5'd6;
	localparam logic [4:0] CYC_ROT         = 5'd2;
	localparam logic [4:0] CYC_NIB         = 5'd10;
	localparam logic [4:0] CYC_NIBL        = 5'd12;
	localparam logic [4:0] CYC_ADJ         = 5'd4;
	localparam logic [4:0] CYC_BIT_HL      = 5'd6;
	localparam logic [4:0] CYC_BIT_HLL     = 5'd7;
	localparam logic [4:0] CYC_BITSET      = 5'd4;
	localparam logic [4:0] CYC_BITSETL     = 5'd6;
	localparam logic [4:0] CYC_PSWBIT      = 5'd6;
	localparam logic [4:0] CYC_CARRY       = 5'd2;
	// divider steps
	localparam int DIV_STEPS = 16;

	// operation codes
	typedef enum logic [4:0] {
		CPUALU_SUB, CPUALU_SUBB, CPUALU_AND, CPUALU_OR, CPUALU_XOR, CPUALU_CMP,
		CPUALU_WADD, CPUALU_WSUB, CPUALU_WCMP, CPUALU_MUL, CPUALU_DIV,
		CPUALU_INC, CPUALU_DEC, CPUALU_ROR, CPUALU_ROL, CPUALU_RTCR, CPUALU_RTCL,
		CPUALU_NIBR, CPUALU_NIBL, CPUALU_ADJA, CPUALU_ADJS,
		CPUALU_BMOVC, CPUALU_BMOVB, CPUALU_BAND, CPUALU_BOR, CPUALU_BXOR,
		CPUALU_BSET, CPUALU_BCLR, CPUALU_CSET, CPUALU_CCLR, CPUALU_CNOT
	} cpualu_op_t;

	// operand source class, decides short or long count
	typedef enum logic [2:0] {
		CPUALU_SRC_NONE, CPUALU_SRC_REG, CPUALU_SRC_IMM, CPUALU_SRC_SADDR,
		CPUALU_SRC_SFR, CPUALU_SRC_PSW, CPUALU_SRC_HL, CPUALU_SRC_IDX
	} cpualu_src_t;

	// request from the sequencer
	typedef struct packed {
		cpualu_op_t  op;
		cpualu_src_t src;
		logic        hiram;
		logic [7:0]  opa;
		logic [7:0]  opb;
		logic [15:0] wimm;
		logic [15:0] addr;
		logic [2:0]  bitsel;
	} cpualu_req_t;

	// result to the sequencer
	typedef struct packed {
		logic [7:0]  res;
		logic        res_we;
		logic [7:0]  res2;
		logic        res2_we;
		logic [4:0]  cycles;
		logic        addr_err;
	} cpualu_rsp_t;
endpackage : cpualu_pkg

// ===== hdl/cpualu_divider.sv
// restoring 16 by 8 unsigned divider, one quotient bit per cycle
// assumes the caller holds start for one cycle and waits for done
`timescale 1ns/100ps
`default_nettype none
module cpualu_divider #(
	parameter int STEPS = cpualu_pkg::DIV_STEPS
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// request
	input  wire logic        start,
	input  wire logic [15:0] dividend,
	input  wire logic [7:0]  divisor,
	// result
	output logic             done,
	output logic [15:0]      quotient,
	output logic [7:0]       remainder
);
	logic [4:0]  count;   // steps still to run
	logic [8:0]  rem;     // partial remainder
	logic [15:0] quo;     // shifting quotient
	logic [8:0]  trial;   // trial remainder
	logic        busy;    // iteration running
	logic [7:0]  dvs;     // divisor held for the whole run

	// trial subtract of the next shifted remainder
	always_comb
	begin
		trial = {rem[7:0], quo[15]} - {1'b0, dvs};
	end

	// iteration; divide by zero gives all ones quotient and dividend low byte
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count <= 5'd0;
			rem   <= 9'h000;
			quo   <= 16'h0000;
			busy  <= 1'b0;
			dvs   <= 8'h00;
			done  <= 1'b0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (start)
			begin
				count <= 5'(STEPS);
				rem   <= 9'h000;
				quo   <= dividend;
				busy  <= 1'b1;
				dvs   <= divisor; // request may change after it is taken
			end
			else if (busy)
			begin
				// shift in a quotient bit
				if (!trial[8] || (dvs == 8'h00))
				begin
					rem <= trial;
					quo <= {quo[14:0], 1'b1};
				end
				else
				begin
					rem <= {rem[7:0], quo[15]};
					quo <= {quo[14:0], 1'b0};
				end
				count <= count - 5'd1;
				if (count == 5'd1)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	// outputs straight from the iteration registers
	assign quotient  = quo;
	assign remainder = rem[7:0];
endmodule // cpualu_divider
`default_nettype wire

// ===== hdl/cpualu_cycle_timer.sv
// counts out the clock budget of one instruction
// assumes load is a single-cycle pulse and busy is read by the top
`timescale 1ns/100ps
`default_nettype none
module cpualu_cycle_timer (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// control
	input  wire logic       load,
	input  wire logic [4:0] cycles,
	// status
	output logic            busy,
	output logic            last
);
	logic [4:0] remain;   // cycles left including the current one

	// down counter, loaded with the budget less one
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			remain <= 5'd0;
		else if (ce)
		begin
			if (load)
				remain <= cycles - 5'd1;
			else if (remain != 5'd0)
				remain <= remain - 5'd1;
		end
	end

	// busy while cycles remain, last on the final one
	assign busy = (remain != 5'd0);
	assign last = (remain == 5'd1);
endmodule // cpualu_cycle_timer
`default_nettype wire

// ===== hdl/cpualu_core.sv
// top of the cpu alu and bit-operation datapath
// assumes the sequencer fetches operands, writes results back and waits for DONE
//
// What this block does
// - subtract, write difference, set Z AC CY
// - subtract with borrow also deducts carry
// - word add/sub/compare on accumulator pair
// - multiply A by X into pair, flags kept
// - divide pair by C, remainder into C
// - increment/decrement set Z AC, keep carry
// - rotates move one bit, carry per kind
// - nibble rotates between A and pointer byte
// - decimal adjust after addition
// - decimal adjust after subtraction
// - carry bit transfer to and from bit
// - carry AND OR XOR with bit
// - set or clear a byte bit
// - status word bit ops change flags directly
// - set, clear, invert carry in 2 clocks
// - short count for fast ram or none
// - one count is one cpu clock
// - flags: result, unaffected, or forced
// - short-direct address within FE20 to FF1F
`timescale 1ns/100ps
`default_nettype none
module cpualu_core (
	// clock, reset, enable
	input  wire logic                 REF_CLK,
	input  wire logic                 RESET,
	input  wire logic                 CE,
	// request from the sequencer
	input  wire logic                 START,
	input  wire cpualu_pkg::cpualu_req_t REQ,
	// answer to the sequencer
	output logic                      BUSY,
	output logic                      DONE,
	output cpualu_pkg::cpualu_rsp_t   RSP,
	// architectural state held here
	output logic [15:0]               AX,
	output logic [7:0]                STATUS_WORD
);
	logic [7:0]  next_res;        // byte result
	logic        next_res_we;     // byte result written back
	logic [7:0]  next_res2;       // second byte result
	logic        next_res2_we;    // second result written back
	logic [15:0] next_ax;         // accumulator pair next
	logic [7:0]  next_psw;        // status word next
	logic [4:0]  next_cycles;     // clock budget
	logic [8:0]  diff;            // byte difference with borrow
	logic [4:0]  ldiff;           // low nibble difference
	logic [16:0] wsum;            // word sum or difference
	logic [4:0]  wlow;            // low nibble of word op
	logic        cy;              // current carry flag
	logic        ac;              // current half-carry flag
	logic        bsel;            // selected bit value
	logic [7:0]  adj;             // decimal adjust value
	logic        adj_cy;          // decimal adjust carry out
	logic        long_form;       // operand outside fast ram
	logic        div_start;       // kick the divider
	logic        div_done;        // divider finished
	logic [15:0] div_q;           // quotient
	logic [7:0]  div_r;           // remainder
	logic        div_pend;        // divide in flight
	logic        tmr_busy;        // timer still counting
	logic        tmr_last;        // final timer cycle
	logic        in_saddr;        // address within short-direct window
	logic        sel_short;       // short-direct operand in use
	logic [15:0] mul_prod;        // multiply product

	assign cy = STATUS_WORD[cpualu_pkg::PSW_CY_BIT];
	assign ac = STATUS_WORD[cpualu_pkg::PSW_AC_BIT];
	assign bsel = (REQ.src == cpualu_pkg::CPUALU_SRC_PSW) ? STATUS_WORD[REQ.bitsel] : REQ.opb[REQ.bitsel];
	assign mul_prod = {8'h00, AX[15:8]} * {8'h00, AX[7:0]}; // A times X

	// short-direct window check
	assign sel_short = (REQ.src == cpualu_pkg::CPUALU_SRC_SADDR);
	assign in_saddr = (REQ.addr >= cpualu_pkg::SADDR_LOW) && (REQ.addr <= cpualu_pkg::SADDR_HIGH);

	// long count whenever the access is not to fast ram
	assign long_form = !REQ.hiram && (REQ.src != cpualu_pkg::CPUALU_SRC_NONE)
		&& (REQ.src != cpualu_pkg::CPUALU_SRC_REG) && (REQ.src != cpualu_pkg::CPUALU_SRC_IMM);

	// borrow chain; carry is unsigned borrow from bit 7, half from bit 3
	always_comb
	begin
		logic sub_in;
		sub_in = (REQ.op == cpualu_pkg::CPUALU_SUBB) && cy;
		diff  = {1'b0, REQ.opa} - {1'b0, REQ.opb} - {8'h00, sub_in};
		ldiff = {1'b0, REQ.opa[3:0]} - {1'b0, REQ.opb[3:0]} - {4'h0, sub_in};
	end

	// word add or subtract with an immediate
	always_comb
	begin
		if (REQ.op == cpualu_pkg::CPUALU_WADD)
		begin
			wsum = {1'b0, AX} + {1'b0, REQ.wimm};
			wlow = {1'b0, AX[3:0]} + {1'b0, REQ.wimm[3:0]};
		end
		else
		begin
			wsum = {1'b0, AX} - {1'b0, REQ.wimm};
			wlow = {1'b0, AX[3:0]} - {1'b0, REQ.wimm[3:0]};
		end
	end

	// decimal adjust for add or subtract on A
	always_comb
	begin
		logic lo_fix;
		logic hi_fix;
		lo_fix = ac || (REQ.op == cpualu_pkg::CPUALU_ADJA && AX[11:8] > 4'h9);
		hi_fix = cy || (REQ.op == cpualu_pkg::CPUALU_ADJA && AX[15:8] > 8'h99);
		adj = {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};
		adj_cy = hi_fix;
	end

	// main operation decode
	always_comb
	begin
		logic [7:0] r;
		r = 8'h00;
		next_res = 8'h00;
		next_res_we = 1'b0;
		next_res2 = 8'h00;
		next_res2_we = 1'b0;
		next_ax = AX;
		next_psw = STATUS_WORD;
		next_cycles = cpualu_pkg::CYC_CARRY;
		div_start = 1'b0;
		unique case (REQ.op)
			cpualu_pkg::CPUALU_SUB, cpualu_pkg::CPUALU_SUBB, cpualu_pkg::CPUALU_CMP:
			begin
				// difference written except for compare
				next_res = diff[7:0];
				next_res_we = (REQ.op != cpualu_pkg::CPUALU_CMP);
				next_psw[cpualu_pkg::PSW_Z_BIT] = (diff[7:0] == 8'h00);
				next_psw[cpualu_pkg::PSW_AC_BIT] = ldiff[4];
				next_psw[cpualu_pkg::PSW_CY_BIT] = diff[8];
				if (sel_short)
					next_cycles = long_form ? cpualu_pkg::CYC_SUBB_SADDRL : cpualu_pkg::CYC_SUBB_SADDR;
				else if (REQ.src == cpualu_pkg::CPUALU_SRC_IDX)
					next_cycles = long_form ? cpualu_pkg::CYC_LOGIC_IDXL : cpualu_pkg::CYC_LOGIC_IDX;
				else
					next_cycles = cpualu_pkg::CYC_SUB_IMM;
			end
			cpualu_pkg::CPUALU_AND, cpualu_pkg::CPUALU_OR, cpualu_pkg::CPUALU_XOR:
			begin
				// logic ops touch only zero
				if (REQ.op == cpualu_pkg::CPUALU_AND)
					r = REQ.opa & REQ.opb;
				else if (REQ.op == cpualu_pkg::CPUALU_OR)
					r = REQ.opa | REQ.opb;
				else
					r = REQ.opa ^ REQ.opb;
				next_res = r;
				next_res_we = 1'b1;
				next_psw[cpualu_pkg::PSW_Z_BIT] = (r == 8'h00);
				if (REQ.src == cpualu_pkg::CPUALU_SRC_IDX)
					next_cycles = long_form ? cpualu_pkg::CYC_LOGIC_IDXL : cpualu_pkg::CYC_LOGIC_IDX;
				else
					next_cycles = cpualu_pkg::CYC_SUB_IMM;
			end
			cpualu_pkg::CPUALU_WADD, cpualu_pkg::CPUALU_WSUB, cpualu_pkg::CPUALU_WCMP:
			begin
				// word ops on the pair; compare keeps it
				if (REQ.op != cpualu_pkg::CPUALU_WCMP)
					next_ax = wsum[15:0];
				next_psw[cpualu_pkg::PSW_Z_BIT] = (wsum[15:0] == 16'h0000);
				next_psw[cpualu_pkg::PSW_AC_BIT] = wlow[4];
				next_psw[cpualu_pkg::PSW_CY_BIT] = wsum[16];
				next_cycles = cpualu_pkg::CYC_WORD;
			end
			cpualu_pkg::CPUALU_MUL:
			begin
				// product of A and X, flags kept
				next_ax = mul_prod;
				next_cycles = cpualu_pkg::CYC_MUL;
			end
			cpualu_pkg::CPUALU_DIV:
			begin
				// result lands when the divider finishes
				div_start = 1'b1;
				next_cycles = cpualu_pkg::CYC_DIV;
			end
			cpualu_pkg::CPUALU_INC, cpualu_pkg::CPUALU_DEC:
			begin
				// carry left alone
				if (REQ.op == cpualu_pkg::CPUALU_INC)
				begin
					r = REQ.opa + 8'h01;
					next_psw[cpualu_pkg::PSW_AC_BIT] = (REQ.opa[3:0] == 4'hF);
				end
				else
				begin
					r = REQ.opa - 8'h01;
					next_psw[cpualu_pkg::PSW_AC_BIT] = (REQ.opa[3:0] == 4'h0);
				end
				next_res = r;
				next_res_we = 1'b1;
				next_psw[cpualu_pkg::PSW_Z_BIT] = (r == 8'h00);
				if (sel_short)
					next_cycles = long_form ? cpualu_pkg::CYC_INC_MEML : cpualu_pkg::CYC_INC_MEM;
				else
					next_cycles = cpualu_pkg::CYC_ROT;
			end
			cpualu_pkg::CPUALU_ROR, cpualu_pkg::CPUALU_ROL, cpualu_pkg::CPUALU_RTCR, cpualu_pkg::CPUALU_RTCL:
			begin
				// one-bit rotates of A
				unique case (REQ.op)
					cpualu_pkg::CPUALU_ROR:  r = {AX[8], AX[15:9]};
					cpualu_pkg::CPUALU_ROL:  r = {AX[14:8], AX[15]};
					cpualu_pkg::CPUALU_RTCR: r = {cy, AX[15:9]};
					default:                 r = {AX[14:8], cy};
				endcase
				next_ax[15:8] = r;
				next_psw[cpualu_pkg::PSW_CY_BIT] = (REQ.op == cpualu_pkg::CPUALU_ROR
					|| REQ.op == cpualu_pkg::CPUALU_RTCR) ? AX[8] : AX[15];
				next_cycles = cpualu_pkg::CYC_ROT;
			end
			cpualu_pkg::CPUALU_NIBR, cpualu_pkg::CPUALU_NIBL:
			begin
				// opa is the pointer byte; A low nibble swaps through
				if (REQ.op == cpualu_pkg::CPUALU_NIBR)
				begin
					next_ax[11:8] = REQ.opa[3:0];
					next_res = {AX[11:8], REQ.opa[7:4]};
				end
				else
				begin
					next_ax[11:8] = REQ.opa[7:4];
					next_res = {REQ.opa[3:0], AX[11:8]};
				end
				next_res_we = 1'b1;
				next_cycles = long_form ? cpualu_pkg::CYC_NIBL : cpualu_pkg::CYC_NIB;
			end
			cpualu_pkg::CPUALU_ADJA, cpualu_pkg::CPUALU_ADJS:
			begin
				// bcd correction of A
				if (REQ.op == cpualu_pkg::CPUALU_ADJA)
					r = AX[15:8] + adj;
				else
					r = AX[15:8] - adj;
				next_ax[15:8] = r;
				next_psw[cpualu_pkg::PSW_Z_BIT] = (r == 8'h00);
				next_psw[cpualu_pkg::PSW_AC_BIT] = 1'b0;
				next_psw[cpualu_pkg::PSW_CY_BIT] = adj_cy;
				next_cycles = cpualu_pkg::CYC_ADJ;
			end
			cpualu_pkg::CPUALU_BMOVC, cpualu_pkg::CPUALU_BAND, cpualu_pkg::CPUALU_BOR, cpualu_pkg::CPUALU_BXOR:
			begin
				// carry combined with selected bit
				unique case (REQ.op)
					cpualu_pkg::CPUALU_BMOVC: next_psw[cpualu_pkg::PSW_CY_BIT] = bsel;
					cpualu_pkg::CPUALU_BAND:  next_psw[cpualu_pkg::PSW_CY_BIT] = cy & bsel;
					cpualu_pkg::CPUALU_BOR:   next_psw[cpualu_pkg::PSW_CY_BIT] = cy | bsel;
					default:                  next_psw[cpualu_pkg::PSW_CY_BIT] = cy ^ bsel;
				endcase
				next_cycles = long_form ? cpualu_pkg::CYC_BIT_HLL : cpualu_pkg::CYC_BIT_HL;
			end
			cpualu_pkg::CPUALU_BMOVB, cpualu_pkg::CPUALU_BSET, cpualu_pkg::CPUALU_BCLR:
			begin
				// write carry or a constant into the selected bit
				r = (REQ.src == cpualu_pkg::CPUALU_SRC_PSW) ? STATUS_WORD : REQ.opb; // status bits edit the live word
				r[REQ.bitsel] = (REQ.op == cpualu_pkg::CPUALU_BMOVB) ? cy
					: (REQ.op == cpualu_pkg::CPUALU_BSET);
				if (REQ.src == cpualu_pkg::CPUALU_SRC_PSW)
				begin
					next_psw = r;
					next_cycles = cpualu_pkg::CYC_PSWBIT;
				end
				else
				begin
					next_res = r;
					next_res_we = 1'b1;
					next_cycles = long_form ? cpualu_pkg::CYC_BITSETL : cpualu_pkg::CYC_BITSET;
				end
			end
			default:
			begin
				// dedicated carry ops
				if (REQ.op == cpualu_pkg::CPUALU_CSET)
					next_psw[cpualu_pkg::PSW_CY_BIT] = 1'b1;
				else if (REQ.op == cpualu_pkg::CPUALU_CCLR)
					next_psw[cpualu_pkg::PSW_CY_BIT] = 1'b0;
				else
					next_psw[cpualu_pkg::PSW_CY_BIT] = !cy;
				next_cycles = cpualu_pkg::CYC_CARRY;
			end
		endcase
	end

	// divider for the word by byte divide
	cpualu_divider #(
		.STEPS(cpualu_pkg::DIV_STEPS)
	) u_div (
		.clk(REF_CLK),
		.rst(RESET),
		.ce(CE),
		.start(START && !BUSY && div_start),
		.dividend(AX),
		.divisor(REQ.opb),
		.done(div_done),
		.quotient(div_q),
		.remainder(div_r)
	);

	// instruction clock budget, one count per clock
	cpualu_cycle_timer u_tmr (
		.clk(REF_CLK),
		.rst(RESET),
		.ce(CE),
		.load(START && !BUSY),
		.cycles(next_cycles),
		.busy(tmr_busy),
		.last(tmr_last)
	);

	assign BUSY = tmr_busy;
	assign DONE = tmr_last;

	// architectural state and answer capture
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			AX <= cpualu_pkg::AX_RESET;
			STATUS_WORD <= cpualu_pkg::PSW_RESET;
			RSP <= '0;
			div_pend <= 1'b0;
		end
		else if (CE)
		begin
			if (START && !BUSY)
			begin
				AX <= next_ax;
				STATUS_WORD <= next_psw;
				RSP.res <= next_res;
				RSP.res_we <= next_res_we;
				RSP.res2 <= next_res2;
				RSP.res2_we <= next_res2_we;
				RSP.cycles <= next_cycles;
				RSP.addr_err <= sel_short && !in_saddr;
				div_pend <= div_start;
			end
			else if (div_done && div_pend)
			begin
				// quotient into pair, remainder back to C
				AX <= div_q;
				RSP.res2 <= div_r;
				RSP.res2_we <= 1'b1;
				div_pend <= 1'b0;
			end
		end
	end

	// carry untouched by increment
	AST_INC_KEEPS_CY: assert property (@(posedge REF_CLK) disable iff (RESET)
		(START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_INC) |=> $stable(STATUS_WORD[0]))
		else $error("increment changed carry");
	// carry set op completes in two clocks
	AST_CARRY_TWO: assert property (@(posedge REF_CLK) disable iff (RESET)
		(START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_CSET) |=> STATUS_WORD[0] && DONE)
		else $error("carry set wrong");
	// multiply flags kept
	AST_MUL_FLAGS: assert property (@(posedge REF_CLK) disable iff (RESET)
		(START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_MUL) |=> $stable(STATUS_WORD))
		else $error("multiply touched flags");
	// compare never writes back
	AST_CMP_NOWB: assert property (@(posedge REF_CLK) disable iff (RESET)
		(START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_CMP) |=> !RSP.res_we)
		else $error("compare wrote operand");
	// zero flag follows result of subtract
	AST_SUB_ZERO: assert property (@(posedge REF_CLK) disable iff (RESET)
		(START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_SUB) |=> STATUS_WORD[6] == (RSP.res == 8'h00))
		else $error("zero flag mismatch");
	// AND leaves carry and half-carry
	AST_LOGIC_FLAGS: assert property (@(posedge REF_CLK) disable iff (RESET)
		(START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_AND) |=> $stable(STATUS_WORD[4]) && $stable(STATUS_WORD[0]))
		else $error("logic op touched carry");
	// divide result arrives within its budget
	sequence div_issue;
		START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_DIV;
	endsequence
	AST_DIV_DONE: assert property (@(posedge REF_CLK) disable iff (RESET)
		div_issue |-> ##[1:24] (div_done && div_pend))
		else $error("divide late");
	// rotate done one clock after issue
	AST_ROT_TIME: assert property (@(posedge REF_CLK) disable iff (RESET)
		(START && !BUSY && CE && REQ.op == cpualu_pkg::CPUALU_ROL) |=> DONE)
		else $error("rotate timing wrong");
endmodule // cpualu_core
`default_nettype wire

// ===== verification/cpualu_seq_model.sv
// partner model: the instruction sequencer, one request at a time
// assumes the bench calls run from one thread while clk runs
`timescale 1ns/100ps
`default_nettype none
module cpualu_seq_model (
	// clock
	input  wire logic                    clk,
	// answer from the datapath
	input  wire logic                    busy,
	input  wire logic                    done,
	// request to the datapath
	output var  logic                    start,
	output var  cpualu_pkg::cpualu_req_t req
);
	// idle request at time zero
	initial
	begin
		start = 1'b0;
		req   = '0;
	end

	// raise, hold to the taking edge, drop, count cycles up to done
	task automatic run(input cpualu_pkg::cpualu_req_t r, output int n);
		while (busy !== 1'b0)
		begin
			@(posedge clk);
			#1;
		end
		start = 1'b1;
		req   = r;
		@(posedge clk);
		#1;
		start = 1'b0;
		req   = ~r; // released fields must not keep the last value
		n     = 2;  // taking cycle plus the one just entered
		while (done !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk); // let busy fall before the next request
		#1;
	endtask
endmodule // cpualu_seq_model
`default_nettype wire

// ===== verification/tb_cpu_alu_and_bit_ops.sv
// self-checking bench for the alu and bit-operation datapath
// assumes cpualu_pkg, the design and the sequencer model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_alu_and_bit_ops;
	logic                    clk, rst, start, busy, done; // clock, reset, handshake
	cpualu_pkg::cpualu_req_t req;                         // request to the datapath
	cpualu_pkg::cpualu_rsp_t rsp;                         // answer from the datapath
	logic [15:0]             ax, w, ad;                   // pair seen, word and address operands
	logic [7:0]              sw;                          // status word seen
	logic [2:0]              bs;                          // bit select operand
	int                      err_total, compares, cyc, n; // counters

	cpualu_core u_dut (.REF_CLK(clk), .RESET(rst), .CE(1'b1), .START(start), .REQ(req),
		.BUSY(busy), .DONE(done), .RSP(rsp), .AX(ax), .STATUS_WORD(sw));
	cpualu_seq_model u_seq (.clk(clk), .busy(busy), .done(done), .start(start), .req(req));

	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// hang guard: the run needs well under 1000 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			test_done();
		end
	end

	// one comparison
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// one request; checks the budget, done timing and z/ac/cy afterwards
	task automatic op(input cpualu_pkg::cpualu_op_t o, input logic [2:0] s, input logic h,
		input logic [7:0] a, input logic [7:0] b, input logic [4:0] c, input logic [2:0] f);
		u_seq.run('{o, cpualu_pkg::cpualu_src_t'(s), h, a, b, w, ad, bs}, n);
		chk("done cycle", {11'h0, c}, 16'(n));
		chk("budget", {11'h0, c}, {11'h0, rsp.cycles});
		chk("z ac cy", {13'h0, f}, {13'h0, sw[6], sw[4], sw[0]});
		ad = 16'hFE20;
	endtask

	// set, invert and clear carry
	task automatic t_carry();
		op(cpualu_pkg::CPUALU_CSET, 3'h0, 1'b1, 8'h00, 8'h00, 5'h2, 3'b001);
		op(cpualu_pkg::CPUALU_CNOT, 3'h0, 1'b1, 8'h00, 8'h00, 5'h2, 3'b000);
		op(cpualu_pkg::CPUALU_CNOT, 3'h0, 1'b1, 8'h00, 8'h00, 5'h2, 3'b001);
		op(cpualu_pkg::CPUALU_CCLR, 3'h0, 1'b1, 8'h00, 8'h00, 5'h2, 3'b000);
		$display("carry test finished");
	endtask

	// subtract, borrow chain and compare
	task automatic t_sub();
		op(cpualu_pkg::CPUALU_SUB, 3'h2, 1'b1, 8'h10, 8'h01, 5'h4, 3'b010);
		chk("sub res", 16'h010F, {7'h0, rsp.res_we, rsp.res});
		op(cpualu_pkg::CPUALU_SUB, 3'h2, 1'b1, 8'h00, 8'h01, 5'h4, 3'b011);
		op(cpualu_pkg::CPUALU_SUBB, 3'h3, 1'b0, 8'h05, 8'h02, 5'h8, 3'b000);
		chk("subtract_with_borrow res", 16'h0002, {8'h00, rsp.res});
		op(cpualu_pkg::CPUALU_CMP, 3'h1, 1'b1, 8'h03, 8'h03, 5'h4, 3'b100);
		chk("cmp write", 16'h0000, {15'h0, rsp.res_we});
		$display("subtract test finished");
	endtask

	// logic ops touch zero only
	task automatic t_logic();
		op(cpualu_pkg::CPUALU_CSET, 3'h0, 1'b1, 8'h00, 8'h00, 5'h2, 3'b101);
		op(cpualu_pkg::CPUALU_AND, 3'h7, 1'b0, 8'hF0, 8'h0F, 5'h9, 3'b101);
		op(cpualu_pkg::CPUALU_OR, 3'h1, 1'b1, 8'hF0, 8'h0F, 5'h4, 3'b001);
		chk("or res", 16'h00FF, {8'h00, rsp.res});
		op(cpualu_pkg::CPUALU_XOR, 3'h1, 1'b1, 8'hFF, 8'hFF, 5'h4, 3'b101);
		$display("logic test finished");
	endtask

	// word ops, multiply and divide on the pair
	task automatic t_word();
		w = 16'h1234;
		op(cpualu_pkg::CPUALU_WADD, 3'h2, 1'b1, 8'h00, 8'h00, 5'h6, 3'b000);
		op(cpualu_pkg::CPUALU_MUL, 3'h1, 1'b1, 8'h00, 8'h00, 5'h10, 3'b000);
		chk("product", 16'h03A8, ax);
		op(cpualu_pkg::CPUALU_DIV, 3'h1, 1'b1, 8'h10, 8'h10, 5'h19, 3'b000);
		chk("quotient", 16'h003A, ax);
		chk("remainder", 16'h0108, {7'h0, rsp.res2_we, rsp.res2});
		w = 16'h0030;
		op(cpualu_pkg::CPUALU_WCMP, 3'h2, 1'b1, 8'h00, 8'h00, 5'h6, 3'b000);
		chk("pair after compare", 16'h003A, ax);
		w = 16'h003B;
		op(cpualu_pkg::CPUALU_WSUB, 3'h2, 1'b1, 8'h00, 8'h00, 5'h6, 3'b011);
		chk("difference", 16'hFFFF, ax);
		$display("word test finished");
	endtask

	// increment and decrement keep carry; window edge is legal
	task automatic t_incdec();
		op(cpualu_pkg::CPUALU_DEC, 3'h3, 1'b1, 8'h10, 8'h00, 5'h4, 3'b011);
		chk("dec res", 16'h000F, {8'h00, rsp.res});
		ad = 16'hFF1F;
		op(cpualu_pkg::CPUALU_INC, 3'h3, 1'b0, 8'hFF, 8'h00, 5'h6, 3'b111);
		chk("inc res", 16'h0000, {7'h0, rsp.addr_err, rsp.res});
		$display("increment test finished");
	endtask

	// the four accumulator rotates in a chain
	task automatic t_rotate();
		cpualu_pkg::cpualu_op_t ro[4] = '{cpualu_pkg::CPUALU_RTCL, cpualu_pkg::CPUALU_ROR,
			cpualu_pkg::CPUALU_RTCR, cpualu_pkg::CPUALU_ROL};
		logic [7:0] ra[4] = '{8'h05, 8'h82, 8'hC1, 8'h83}; // accumulator after each rotate
		logic [2:0] rf[4] = '{3'b011, 3'b011, 3'b010, 3'b011}; // flags after each rotate
		w = 16'h8201;
		op(cpualu_pkg::CPUALU_WADD, 3'h2, 1'b1, 8'h00, 8'h00, 5'h6, 3'b011);
		for (int i = 0; i < 4; i++)
		begin
			op(ro[i], 3'h0, 1'b1, ax[15:8], 8'h00, 5'h2, rf[i]);
			chk("rotated accumulator", {8'h00, ra[i]}, {8'h00, ax[15:8]});
		end
		$display("rotate test finished");
	endtask

	// bit set and clear, window check, carry logic, status bits, nibbles, bcd
	task automatic t_bits();
		bs = 3'h5;
		op(cpualu_pkg::CPUALU_BSET, 3'h3, 1'b1, 8'h00, 8'h00, 5'h4, 3'b011);
		chk("set res", 16'h0020, {7'h0, rsp.addr_err, rsp.res});
		bs = 3'h7;
		ad = 16'hFF00;
		op(cpualu_pkg::CPUALU_BCLR, 3'h3, 1'b0, 8'h00, 8'hFF, 5'h6, 3'b011);
		chk("clear res", 16'h007F, {8'h00, rsp.res});
		ad = 16'hFF20;
		op(cpualu_pkg::CPUALU_BSET, 3'h3, 1'b1, 8'h00, 8'h00, 5'h4, 3'b011);
		chk("window", 16'h0001, {15'h0, rsp.addr_err});
		bs = 3'h2;
		op(cpualu_pkg::CPUALU_BAND, 3'h6, 1'b0, 8'h00, 8'h08, 5'h7, 3'b010);
		bs = 3'h3;
		op(cpualu_pkg::CPUALU_BOR, 3'h6, 1'b0, 8'h00, 8'h08, 5'h7, 3'b011);
		op(cpualu_pkg::CPUALU_BXOR, 3'h6, 1'b0, 8'h00, 8'h08, 5'h7, 3'b010);
		bs = 3'h6;
		op(cpualu_pkg::CPUALU_BSET, 3'h5, 1'b0, 8'h00, 8'h00, 5'h6, 3'b110);
		op(cpualu_pkg::CPUALU_NIBR, 3'h6, 1'b1, 8'hA5, 8'h00, 5'hA, 3'b110);
		chk("nibble", 16'h853A, {ax[15:8], rsp.res});
		op(cpualu_pkg::CPUALU_ADJS, 3'h0, 1'b1, 8'h00, 8'h00, 5'h4, 3'b000);
		chk("bcd sub", 16'h007F, {8'h00, ax[15:8]});
		op(cpualu_pkg::CPUALU_ADJA, 3'h0, 1'b1, 8'h00, 8'h00, 5'h4, 3'b000);
		chk("bcd add", 16'h0085, {8'h00, ax[15:8]});
		op(cpualu_pkg::CPUALU_BMOVC, 3'h6, 1'b1, 8'h00, 8'h40, 5'h6, 3'b001);
		op(cpualu_pkg::CPUALU_BMOVB, 3'h1, 1'b1, 8'h00, 8'h00, 5'h4, 3'b001);
		chk("bit from carry", 16'h0140, {7'h0, rsp.res_we, rsp.res});
		$display("bit test finished");
	endtask

	// counts and verdict, then stop
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// reset for 8 cycles, then the scenarios
	initial
	begin
		rst = 1'b1;
		w = 16'h0000;
		ad = 16'hFE20;
		bs = 3'h0;
		err_total = 0;
		compares = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("reset pair", 16'h0000, ax);
		chk("reset status", 16'h0002, {7'h0, busy, sw});
		t_carry();
		t_sub();
		t_logic();
		t_word();
		t_incdec();
		t_rotate();
		t_bits();
		test_done();
	end
endmodule // tb_cpu_alu_and_bit_ops
`default_nettype wire
